// File: hw/vmac_pkg.sv
// Package with constants, types and operation codes for the vector multiply-accumulate datapath
// Functional notes
// - Each lane i picks operand lane j from the 4-bit selector: 0000 gives i, 001x quarter, 01xx half, 1xxx whole.
// - Oddify ignores both sources and adds +32<<16 when the accumulator is negative with bit 21 clear, -32<<16 when positive with bit 21 clear, else zero.
// - After oddify, accumulator bits 32..17 are saturated to signed 16 bits and written to the destination lane.
// - Unsigned-fraction accumulate adds the product shifted left one bit to accumulator bits 47..16.
// - Unsigned-fraction accumulate writes accumulator bits 31..16 saturated to unsigned 16 bits.
// - High-partial accumulate adds the product shifted up 16 bits to accumulator bits 47..16.
// - Low-partial accumulate adds product bits 31..16 to accumulator bits 15..0.
// - Both mid-partial accumulate forms add the full 32-bit product to accumulator bits 31..0.
// - High-partial accumulate, integer-by-fraction mid accumulate and high multiply-load write bits 31..16 saturated signed.
// - Low-partial accumulate and fraction-by-integer mid accumulate write bits 15..0 saturated signed.
// - Element move copies the selected second-source element into the destination element and into accumulator bits 15..0.
// - Lane merge takes first source where the compare flag is set, else second source, into destination and accumulator bits 15..0.
// - Lane merge leaves the compare, carry and compare-extension flags unchanged.
// - High multiply-load replaces the accumulator with the product shifted up 16 bits.
package vmac_pkg;
    localparam int LANES     = 8;
    localparam int EW        = 16;
    localparam int AW        = 48;
    localparam int PW        = 32;
    localparam int SELW      = 4;
    localparam int LIDXW     = 3;
    localparam int ODD_BIT   = 21;
    localparam int ODD_SHIFT = 16;
    localparam logic [AW-1:0] ODD_STEP = AW'(32) << ODD_SHIFT;
    localparam int HI_SHIFT  = 16;
    localparam int SLICE_HI  = 16;
    localparam int SLICE_LO  = 0;
    localparam int SLICE_OD  = 17;
    localparam logic signed [EW-1:0] SMAX = 16'h7FFF;
    localparam logic signed [EW-1:0] SMIN = 16'h8000;
    localparam logic [EW-1:0] UMAX = 16'hFFFF;
    localparam logic [EW-1:0] UMIN = 16'h0000;
    localparam logic [SELW-1:0] SEL_VEC = 4'h0;
    localparam logic [SELW-1:0] M_QTR   = 4'hE;
    localparam logic [SELW-1:0] V_QTR   = 4'h2;
    localparam logic [SELW-1:0] M_HALF  = 4'hC;
    localparam logic [SELW-1:0] V_HALF  = 4'h4;
    localparam logic [SELW-1:0] M_WHOLE = 4'h8;
    localparam logic [AW-1:0] ACC_RST  = 48'h000000000000;
    localparam logic [EW-1:0] ELEM_RST = 16'h0000;

    typedef enum logic [3:0] {
        OP_NOP   = 4'h0,
        OP_ODD   = 4'h1,
        OP_MACU  = 4'h3,
        OP_MADH  = 4'h2,
        OP_MADL  = 4'h6,
        OP_MADM  = 4'h7,
        OP_MADN  = 4'h5,
        OP_MOV   = 4'h4,
        OP_MRG   = 4'hC,
        OP_MUDH  = 4'hD
    } vop_t;

    typedef logic [LANES-1:0][EW-1:0] vec_t;

    typedef struct packed {
        vop_t             op;
        logic [SELW-1:0]  sel;
        logic [LIDXW-1:0] dest_elem;
        vec_t             first_src;
        vec_t             second_src;
        vec_t             dest_old;
        logic [LANES-1:0] compare_flags;
    } vreq_t;

    typedef struct packed {
        logic             valid;
        vec_t             dest_vec;
        logic [LANES-1:0] lane_wr;
    } vres_t;
endpackage : vmac_pkg

// File: hw/vmac_lane.sv
// One lane: operand multiply, accumulator update and saturated write-back slice
`timescale 1ns/1ps
module vmac_lane
    import vmac_pkg::*;
(
    input  wire logic                    clk_sys_i,
    input  wire logic                    rst_i,
    input  wire logic                    issue_i,
    input  vmac_pkg::vop_t               op_i,
    input  wire logic [vmac_pkg::EW-1:0] a_i,
    input  wire logic [vmac_pkg::EW-1:0] b_i,
    input  wire logic [vmac_pkg::EW-1:0] load_i,
    output logic      [vmac_pkg::EW-1:0] res_o,
    output logic      [vmac_pkg::AW-1:0] acc_o
);
    logic signed [AW-1:0] acc;
    logic signed [PW-1:0] prod;
    logic signed [AW-1:0] next_acc;
    logic signed [AW-1:0] odd_add;
    logic signed [AW-1:0] p_hi, p_lo, p_full, p_uf;
    logic        [EW-1:0] next_res;

    // Signed lane product and its shifted forms, sign-extended to accumulator width
    assign prod   = $signed(a_i) * $signed(b_i);
    assign p_hi   = AW'(prod) <<< HI_SHIFT;
    assign p_lo   = AW'(prod >>> HI_SHIFT);
    assign p_full = AW'(prod);
    assign p_uf   = AW'({prod[PW-2:0], 1'b0}) << HI_SHIFT;                                // Fills bits 47..16 exactly

    // Oddify step chosen from sign and bit 21
    assign odd_add = (acc < 0 && !acc[ODD_BIT]) ? signed'(ODD_STEP) :
                     (acc > 0 && !acc[ODD_BIT]) ? -signed'(ODD_STEP) : '0;

    // Saturate a slice of v starting at bit lo, judged on the full value
    function automatic logic [EW-1:0] sat_s(input logic signed [AW:0] v, input int lo);
        logic signed [AW:0] s;
        s = v >>> lo;
        if (s > SMAX) return SMAX;
        else if (s < SMIN) return SMIN;
        else return s[EW-1:0];
    endfunction : sat_s

    function automatic logic [EW-1:0] sat_u(input logic signed [AW:0] v, input int lo);
        logic signed [AW:0] s;
        s = v >>> lo;
        if (s > $signed({1'b0, UMAX})) return UMAX;
        else if (s < 0) return UMIN;
        else return s[EW-1:0];
    endfunction : sat_u

    // Next accumulator and write-back value per operation
    always_comb begin
        next_acc = acc;
        next_res = res_o;
        case (op_i)
            OP_ODD: begin
                next_acc = acc + odd_add;
                next_res = sat_s(next_acc, SLICE_OD);
            end
            OP_MACU: begin
                next_acc = acc + p_uf;
                next_res = sat_u(next_acc, SLICE_HI);
            end
            OP_MADH: begin
                next_acc = acc + p_hi;
                next_res = sat_s(next_acc, SLICE_HI);
            end
            OP_MADL: begin
                next_acc = acc + p_lo;
                next_res = sat_s(next_acc, SLICE_LO);
            end
            OP_MADM: begin
                next_acc = acc + p_full;
                next_res = sat_s(next_acc, SLICE_HI);
            end
            OP_MADN: begin
                next_acc = acc + p_full;
                next_res = sat_s(next_acc, SLICE_LO);
            end
            OP_MUDH: begin
                next_acc = p_hi;
                next_res = sat_s(next_acc, SLICE_HI);
            end
            OP_MOV, OP_MRG: begin
                next_acc = {acc[AW-1:EW], load_i};
                next_res = load_i;
            end
            default: begin
                next_acc = acc;
                next_res = res_o;
            end
        endcase
    end

    // Accumulator persists between instructions
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            acc   <= ACC_RST;
            res_o <= ELEM_RST;
        end else if (issue_i) begin
            acc   <= next_acc;
            res_o <= next_res;
        end
    end

    assign acc_o = acc;
endmodule : vmac_lane

// File: hw/vmac_datapath.sv
// Eight-lane vector multiply-accumulate, element move and lane merge datapath
`timescale 1ns/1ps
module vmac_datapath
    import vmac_pkg::*;
(
    input  wire logic                         clk_sys_i,
    input  wire logic                         rst_i,
    input  wire logic                         issue_i,
    input  vmac_pkg::vreq_t                   req_i,
    output vmac_pkg::vres_t                   res_o,
    output logic [vmac_pkg::LANES-1:0][vmac_pkg::AW-1:0] acc_o
);
    vec_t             lane_res;
    vec_t             opnd_b;
    vec_t             load_val;
    logic             is_mov;
    logic [EW-1:0]    mov_elem;
    logic [LANES-1:0] next_wr;
    logic             valid_q;
    logic [LANES-1:0] wr_q;

    // Element move takes the selector's low three bits as the source element
    assign is_mov   = (req_i.op == OP_MOV);
    assign mov_elem = req_i.second_src[req_i.sel[LIDXW-1:0]];

    // Per-lane operand selection and lane instances
    for (genvar i = 0; i < LANES; i++) begin : g_lane
        logic [LIDXW-1:0] j;
        logic [LIDXW-1:0] li;
        assign li = LIDXW'(i);
        assign j  = (req_i.sel == SEL_VEC)              ? li :
                    ((req_i.sel & M_QTR) == V_QTR)      ? ((req_i.sel[LIDXW-1:0] & 3'h1) + (li & 3'h6)) :
                    ((req_i.sel & M_HALF) == V_HALF)    ? ((req_i.sel[LIDXW-1:0] & 3'h3) + (li & 3'h4)) :
                    ((req_i.sel & M_WHOLE) == M_WHOLE)  ? req_i.sel[LIDXW-1:0] : li;
        assign opnd_b[i]   = req_i.second_src[j];
        assign load_val[i] = is_mov ? mov_elem :
                             (req_i.compare_flags[i] ? req_i.first_src[i] : opnd_b[i]);

        vmac_lane u_lane (
            .clk_sys_i (clk_sys_i),
            .rst_i     (rst_i),
            .issue_i   (issue_i && (!is_mov || req_i.dest_elem == li)),
            .op_i      (req_i.op),
            .a_i       (req_i.first_src[i]),
            .b_i       (opnd_b[i]),
            .load_i    (load_val[i]),
            .res_o     (lane_res[i]),
            .acc_o     (acc_o[i])
        );
    end

    // Lanes written: none for a no-op, only the named element for a move, else all lanes
    always_comb begin
        next_wr = '0;
        for (int k = 0; k < LANES; k++) begin
            next_wr[k] = (req_i.op != OP_NOP) && (!is_mov || req_i.dest_elem == LIDXW'(k));
        end
    end

    // Result strobe one cycle after issue; flags are not driven by this block
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            valid_q <= 1'b0;
            wr_q    <= '0;
        end else begin
            valid_q <= issue_i && (req_i.op != OP_NOP);
            wr_q    <= issue_i ? next_wr : '0;
        end
    end

    assign res_o.valid    = valid_q;
    assign res_o.dest_vec = lane_res;
    assign res_o.lane_wr  = wr_q;
endmodule : vmac_datapath

// File: verif/vmac_issue_model.sv
// Issue stage model that presents one instruction per request
`timescale 1ns/1ps
module vmac_issue_model
    import vmac_pkg::*;
(
    input  wire logic      clk_sys_i,
    input  wire logic      rst_i,
    input  wire logic      go_i,
    input  vmac_pkg::vreq_t cmd_i,
    output logic           issue_o,
    output vmac_pkg::vreq_t req_o
);
    // One-cycle strobe; request bits churn while idle so stale fields are never trusted
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            issue_o <= 1'b0;
            req_o   <= '0;
        end else begin
            issue_o <= go_i;
            req_o   <= go_i ? cmd_i : ~req_o;
        end
    end
endmodule : vmac_issue_model

// File: verif/vmac_datapath_props.sv
// Port-level checker for the vector multiply-accumulate datapath
`timescale 1ns/1ps
module vmac_datapath_props
    import vmac_pkg::*;
(
    input wire logic                                 clk_sys_i,
    input wire logic                                 rst_i,
    input wire logic                                 issue_i,
    input vmac_pkg::vreq_t                           req_i,
    input vmac_pkg::vres_t                           res_o,
    input logic [vmac_pkg::LANES-1:0][vmac_pkg::AW-1:0] acc_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // Issue of a defined operation other than no-op, and of the two per-element kinds
    wire logic known = issue_i && (req_i.op inside {OP_ODD, OP_MACU, OP_MADH, OP_MADL, OP_MADM, OP_MADN, OP_MOV,
                                                    OP_MRG, OP_MUDH});
    wire logic mov = issue_i && (req_i.op == OP_MOV);
    wire logic mrg = issue_i && (req_i.op == OP_MRG);

    result_pulse_a: assert property (known |=> res_o.valid) else $error("no result after issue");
    idle_hold_a: assert property (!issue_i |=> !res_o.valid && $stable(acc_o)) else $error("change without issue");
    all_lanes_a: assert property (known && !mov |=> res_o.lane_wr == 8'hFF) else $error("lane write mask");
    move_mask_a: assert property (mov |=> res_o.lane_wr == (8'h01 << $past(req_i.dest_elem)))
        else $error("move lane mask");
    move_data_a: assert property (mov |=> res_o.dest_vec[$past(req_i.dest_elem)] ==
        $past(req_i.second_src[req_i.sel[2:0]])) else $error("move data");
    merge_pick_a: assert property (mrg && req_i.sel == SEL_VEC |=> res_o.dest_vec[0] ==
        ($past(req_i.compare_flags[0]) ? $past(req_i.first_src[0]) : $past(req_i.second_src[0])))
        else $error("merge pick");
    merge_acc_a: assert property (mrg |=> acc_o[7][15:0] == res_o.dest_vec[7]) else $error("merge acc");
    load_high_a: assert property (issue_i && req_i.op == OP_MUDH && req_i.sel == SEL_VEC |=>
        $signed(acc_o[0]) == $signed($past(req_i.first_src[0])) * $signed($past(req_i.second_src[0])) * 48'sd65536)
        else $error("load high");

    odd_seen_c: cover property (issue_i && req_i.op == OP_ODD);
    move_seen_c: cover property (mov);
    merge_seen_c: cover property (mrg);
endmodule : vmac_datapath_props

bind vmac_datapath vmac_datapath_props chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .issue_i(issue_i), .req_i(req_i),
    .res_o(res_o), .acc_o(acc_o));

// File: verif/vmac_datapath_bench.sv
// Self-checking bench for the vector multiply-accumulate datapath
`timescale 1ns/1ps
module vmac_datapath_bench;
    import vmac_pkg::*;
    logic  clk_sys_i, rst_i, go, issue;
    vreq_t cmd, req;
    vres_t res;
    vec_t  fs, ss;
    logic  [LANES-1:0][AW-1:0] acc;
    int    n_fail = 0;
    int    num_checks = 0;

    vmac_issue_model model (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .go_i(go), .cmd_i(cmd), .issue_o(issue), .req_o(req));
    vmac_datapath dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .issue_i(issue), .req_i(req), .res_o(res), .acc_o(acc));

    // System clock
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic end_of_test;
        if (n_fail == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [AW-1:0] seen, input logic [AW-1:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Issue through the model, then look at the result in its one valid cycle
    task automatic run(input vop_t op, input logic [3:0] sel, input logic [2:0] de, input logic [7:0] cf);
        @(posedge clk_sys_i);
        go  <= 1'b1;
        cmd <= '{op, sel, de, fs, ss, vec_t'(0), cf};
        @(posedge clk_sys_i);
        go  <= 1'b0;
        @(posedge clk_sys_i);
        #1;
        chk("valid", res.valid, op != OP_NOP);
    endtask : run

    task automatic lane(input int i, input logic [AW-1:0] a, input logic [EW-1:0] d);
        chk("acc", acc[i], a);
        chk("dest", res.dest_vec[i], d);
    endtask : lane

    function automatic int pick(input logic [3:0] s, input int i);
        if (s == 4'h0) begin
            return i;
        end else if ((s & 4'hE) == 4'h2) begin
            return int'(s[0]) + (i & 6);
        end else if ((s & 4'hC) == 4'h4) begin
            return int'(s[1:0]) + (i & 4);
        end
        return int'(s[2:0]);
    endfunction : pick

    // Every operand selection form under load-high, then accumulate-high
    task automatic t_select;
        logic [3:0] sels [6] = '{4'h0, 4'h3, 4'h5, 4'h6, 4'hB, 4'hF};
        int p;
        for (int i = 0; i < LANES; i++) begin
            fs[i] = EW'(i + 1);
            ss[i] = EW'(i + 2);
        end
        foreach (sels[k]) begin
            run(OP_MUDH, sels[k], 3'h0, 8'h00);
            for (int i = 0; i < LANES; i++) begin
                p = (i + 1) * (pick(sels[k], i) + 2);
                lane(i, AW'(p) << 16, EW'(p));
            end
        end
        run(OP_MADH, 4'h0, 3'h0, 8'h00);
        for (int i = 0; i < LANES; i++) begin
            p = (i + 1) * (i + 11);
            lane(i, AW'(p) << 16, EW'(p));
        end
    endtask : t_select

    // Mid, low and unsigned accumulate chain with saturated slices
    task automatic t_mid;
        fs = '0;
        run(OP_MUDH, 4'h0, 3'h0, 8'h00);
        fs = {LANES{16'h0100}};
        ss = fs;
        run(OP_MADN, 4'h0, 3'h0, 8'h00);
        lane(2, 48'h000000010000, 16'h7FFF);
        run(OP_MADL, 4'h0, 3'h0, 8'h00);
        lane(5, 48'h000000010001, 16'h7FFF);
        run(OP_MADM, 4'h0, 3'h0, 8'h00);
        lane(7, 48'h000000020001, 16'h0002);
        run(OP_MACU, 4'h0, 3'h0, 8'h00);
        lane(0, 48'h000200020001, 16'hFFFF);
    endtask : t_mid

    // Oddify both signs, then again with bit 21 now set
    task automatic t_odd;
        for (int i = 0; i < LANES; i++) begin
            fs[i] = i[0] ? 16'h0040 : 16'hFFC0;
            ss[i] = 16'h0001;
        end
        run(OP_MUDH, 4'h0, 3'h0, 8'h00);
        repeat (2) begin
            fs = ~fs;
            run(OP_ODD, 4'h0, 3'h0, 8'h00);
            lane(4, 48'hFFFFFFE00000, 16'hFFF0);
            lane(5, 48'h000000200000, 16'h0010);
        end
    endtask : t_odd

    // Element move into one lane, then merge and an ignored no-op
    task automatic t_move_merge;
        for (int i = 0; i < LANES; i++) begin
            fs[i] = 16'h1000 + EW'(i);
            ss[i] = 16'hA000 + EW'(i);
        end
        run(OP_MOV, 4'h3, 3'h5, 8'h00);
        chk("lane_wr", res.lane_wr, 48'h20);
        lane(5, 48'h00000020A003, 16'hA003);
        chk("acc", acc[4], 48'hFFFFFFE00000);
        run(OP_MRG, 4'h0, 3'h0, 8'hA5);
        for (int i = 0; i < LANES; i++) begin
            lane(i, {(i[0] ? 32'h00000020 : 32'hFFFFFFE0), (i == 0 || i == 2 || i == 5 || i == 7) ? fs[i] : ss[i]},
                 (8'hA5 >> i) & 1 ? fs[i] : ss[i]);
        end
        run(OP_NOP, 4'h0, 3'h0, 8'h00);
        chk("acc", acc[0], 48'hFFFFFFE01000);
    endtask : t_move_merge

    // Mid-run reset clears accumulators and results; the first issue after release lands
    task automatic t_reset;
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        #1;
        chk("valid", res.valid, 1'b0);
        for (int i = 0; i < LANES; i++) begin
            lane(i, '0, '0);
        end
        run(OP_MOV, 4'h2, 3'h0, 8'h00);
        lane(0, 48'h00000000A002, 16'hA002);
    endtask : t_reset

    // Reset, then the scenarios in turn
    initial begin
        rst_i = 1'b1;
        go    = 1'b0;
        cmd   = '0;
        fs    = '0;
        ss    = '0;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        for (int i = 0; i < LANES; i++) chk("acc", acc[i], '0);
        t_select();
        t_mid();
        t_odd();
        t_move_merge();
        t_reset();
        end_of_test();
    end

    // Watchdog against a hang
    initial begin
        repeat (1000) @(posedge clk_sys_i);
        n_fail++;
        end_of_test();
    end
endmodule : vmac_datapath_bench
